//--- common/snd_pkg.sv
// Shared constants and carrier types for the nibble link transmitter and its diagnostics
package snd_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_UNIT_NS = 500;
  localparam int TICK_UNIT_CYC = (TICK_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOGIC_TEST_MS = 10;
  localparam int LOGIC_TEST_CYC = LOGIC_TEST_MS * 1000000 / CLK_PERIOD_NS;
  localparam int RING_STEP_NS = 10000;
  localparam int RING_STEP_CYC = RING_STEP_NS / CLK_PERIOD_NS;
  localparam int RING_ELEMENTS = 32;
  localparam int RING_IDX_W = 5;
  localparam int ANGLE_W = 12;
  localparam int REG_W = 24;
  localparam int CFG_N = 8;

  // Register addresses
  localparam logic [7:0] ADDR_ANGLE = 8'h00;
  localparam logic [7:0] ADDR_ERR = 8'h04;
  localparam logic [7:0] ADDR_FAULT_REGISTER_B = 8'h05;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_RING_SEL = 8'h0A;
  localparam logic [7:0] ADDR_RING_DATA = 8'h0B;
  localparam logic [7:0] CFG_ADDR [CFG_N] = '{8'h11, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1E, 8'h1F};
  localparam logic [2:0] CFG_LINK = 3'h3;
  localparam logic [2:0] CFG_CUST_A = 3'h4;
  localparam logic [2:0] CFG_ERR_MASK = 3'h6;
  localparam logic [REG_W-1:0] CFG_RESET = 24'h000000;

  // Field positions
  localparam int CTRL_ERR_CLR_BIT = 0;
  localparam int CTRL_LOGIC_TEST_BIT = 3;
  localparam int CTRL_RING_TEST_BIT = 4;
  localparam int CTRL_LOGIC_PASS_BIT = 5;
  localparam int LINK_TICK_LSB = 2;
  localparam int LINK_TICK_W = 6;
  localparam int LINK_DATA_MODE_BIT = 11;
  localparam int LINK_SERIAL_BIT = 14;
  localparam int LINK_PAUSE_BIT = 20;
  localparam int WEAK_LIMIT_LSB = 0;
  localparam int UV_OUT_BIT = 2;

  // Error flag layout
  localparam int ERR_SUPPLY = 0;
  localparam int ERR_WEAK = 1;
  localparam int ERR_INTERNAL = 2;
  localparam int ERR_TEMP = 4;
  localparam int ERR_ECC_CORR = 5;
  localparam int ERR_ECC_DET = 6;
  localparam logic [6:0] ERR_RESET = 7'h01;
  localparam int FAULT_REGISTER_B_RING = 3;
  localparam int FAULT_REGISTER_B_LOGIC = 4;
  localparam logic [6:0] FAULT_REGISTER_B_RESET = 7'h00;

  // Frame timing in ticks
  localparam logic [8:0] NIB_LOW_TICKS = 9'h005;
  localparam logic [8:0] NIB_BASE_TICKS = 9'h00C;
  localparam logic [8:0] SYNC_TICKS = 9'h038;
  localparam logic [8:0] FRAME_TICKS = 9'h12C;
  localparam logic [2:0] DATA_LAST_SHORT = 3'h2;
  localparam logic [2:0] DATA_LAST_LONG = 3'h5;

  localparam logic [3:0] CRC_SEED = 4'h5;
  localparam logic [3:0] CRC_POLY = 4'hD;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  localparam logic [11:0] RING_TOL = 12'h010;

  typedef enum logic [2:0] {FR_SYNC, FR_STATUS, FR_DATA, FR_CRC, FR_PAUSE} snd_frame_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [REG_W-1:0] wdata;
    logic wr;
    logic rd;
  } snd_reg_req_s;

  typedef struct packed {
    logic supply_lost;
    logic undervolt;
    logic temp_bad;
    logic logic_fault;
  } snd_pins_s;
endpackage

//--- hw/snd_crc4.sv
// Nibble-serial four-bit checksum for the link frame
`timescale 1ns/1ps
module snd_crc4 (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic feed,
  input wire logic [3:0] nib,
  output logic [3:0] crc
);
  logic [3:0] crc_q;

  function automatic logic [3:0] crc_step(input logic [3:0] c, input logic [3:0] n);
    logic [3:0] r;
    r = c;
    for (int i = 0; i < 4; i++) begin
      if (r[3]) begin
        r = {r[2:0], 1'b0} ^ snd_pkg::CRC_POLY;
      end else begin
        r = {r[2:0], 1'b0};
      end
    end
    return r ^ n;
  endfunction

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      crc_q <= snd_pkg::CRC_SEED;
    end else if (start) begin
      crc_q <= crc_step(snd_pkg::CRC_SEED, nib);
    end else if (feed) begin
      crc_q <= crc_step(crc_q, nib);
    end
  end

  // Augment with a zero nibble so a trailing error still changes the result
  assign crc = crc_step(crc_q, 4'h0);
endmodule // snd_crc4

//--- hw/snd_ring_mem.sv
// Store of per-element angle results from the sensing ring sweep
`timescale 1ns/1ps
module snd_ring_mem (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic wr_en,
  input wire logic [4:0] wr_addr,
  input wire logic [11:0] wr_data,
  input wire logic [4:0] rd_addr,
  output logic [11:0] rd_data_q
);
  logic [11:0] mem [snd_pkg::RING_ELEMENTS];

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data_q <= 12'h000;
    end else begin
      rd_data_q <= mem[rd_addr];
    end
  end
endmodule // snd_ring_mem

//--- hw/snd_top.sv
// Nibble link frame transmitter with self-test and error flag logic
`timescale 1ns/1ps
module snd_top #(
  parameter int unsigned LOGIC_TEST_CYCLES = snd_pkg::LOGIC_TEST_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input snd_pkg::snd_reg_req_s reg_req,
  output logic [23:0] reg_rdata_q,
  output logic reg_rvalid_q,
  input snd_pkg::snd_pins_s pins,
  input wire logic [11:0] angle_in,
  input wire logic [11:0] field_level,
  input wire logic ecc_detected,
  input wire logic ecc_corrected,
  input wire logic ring_req_link,
  output logic ring_bias_en_q,
  output logic [4:0] ring_bias_sel_q,
  output logic test_busy_q,
  output logic link_out_q
);
  localparam int NPIN = 4;

  logic [NPIN-1:0] pin_vec, pin_sync;
  logic supply_lost_s, undervolt_s, temp_bad_s, logic_fault_s;
  logic [23:0] cfg_q [snd_pkg::CFG_N];
  logic [3:0] wr_slot, rd_slot;
  logic [23:0] link_cfg, cust_a, err_mask;
  logic ctrl_wr, err_clr;
  logic [6:0] err_q, fault_register_b_q, err_set, fault_register_b_set;
  logic [9:0] tick_len, tick_cnt_q;
  logic tick_stb, nib_end;
  snd_pkg::snd_frame_e state_q;
  logic [8:0] nib_tick_q, nib_len, frame_tick_q, pause_len_q;
  logic [3:0] nib_val_q, status_d, ser_cnt_q, crc_val;
  logic [2:0] data_idx_q, data_last;
  logic long_mode_q, sync_end, any_err;
  logic [23:0] snap_q;
  logic [15:0] ser_word;
  logic lt_start, lt_busy_q, lt_fail_q, lt_done_q, lt_pass_q;
  logic [17:0] lt_cnt_q;
  logic [15:0] lfsr_a_q, lfsr_b_q;
  logic rt_start, ring_wr, angle_bad;
  logic [7:0] rt_step_q;
  logic [11:0] angle_diff;
  logic [4:0] ring_rd_sel_q;
  logic [11:0] ring_rd_data;
  logic [23:0] rd_val;

  function automatic logic [3:0] cfg_slot(input logic [7:0] a);
    cfg_slot = 4'h0;
    for (int i = 0; i < snd_pkg::CFG_N; i++) begin
      if (a == snd_pkg::CFG_ADDR[i]) begin
        cfg_slot = {1'b1, 3'(i)};
      end
    end
  endfunction

  function automatic logic [3:0] nib_of(input logic [23:0] d, input logic [2:0] idx);
    return d[5'(23 - 4 * int'(idx)) -: 4];
  endfunction

  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Asynchronous pins are brought in through two flip-flops each
  assign pin_vec = pins;
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      logic s1_q, s2_q;
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
        end else begin
          s1_q <= pin_vec[gi];
          s2_q <= s1_q;
        end
      end
      assign pin_sync[gi] = s2_q;
    end
  endgenerate
  assign supply_lost_s = pin_sync[3];
  assign undervolt_s = pin_sync[2];
  assign temp_bad_s = pin_sync[1];
  assign logic_fault_s = pin_sync[0];

  // Configuration registers
  assign wr_slot = cfg_slot(reg_req.addr);
  assign rd_slot = wr_slot;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < snd_pkg::CFG_N; i++) begin
        cfg_q[i] <= snd_pkg::CFG_RESET;
      end
    end else if (reg_req.wr && wr_slot[3]) begin
      cfg_q[wr_slot[2:0]] <= reg_req.wdata;
    end
  end
  assign link_cfg = cfg_q[snd_pkg::CFG_LINK];
  assign cust_a = cfg_q[snd_pkg::CFG_CUST_A];
  assign err_mask = cfg_q[snd_pkg::CFG_ERR_MASK];

  // Error flags: sticky, a set in the clear cycle survives
  assign ctrl_wr = reg_req.wr && (reg_req.addr == snd_pkg::ADDR_CTRL);
  assign err_clr = ctrl_wr && reg_req.wdata[snd_pkg::CTRL_ERR_CLR_BIT];
  always_comb begin
    err_set = 7'h00;
    err_set[snd_pkg::ERR_SUPPLY] = supply_lost_s;
    err_set[snd_pkg::ERR_WEAK] = field_level[11:4] < cust_a[snd_pkg::WEAK_LIMIT_LSB +: 8];
    err_set[snd_pkg::ERR_INTERNAL] = logic_fault_s || (state_q == snd_pkg::FR_DATA && data_idx_q > data_last);
    err_set[snd_pkg::ERR_TEMP] = temp_bad_s;
    err_set[snd_pkg::ERR_ECC_CORR] = ecc_corrected;
    err_set[snd_pkg::ERR_ECC_DET] = ecc_detected;
    fault_register_b_set = 7'h00;
    fault_register_b_set[snd_pkg::FAULT_REGISTER_B_RING] = ring_wr && angle_bad;
    fault_register_b_set[snd_pkg::FAULT_REGISTER_B_LOGIC] = lt_done_q && lt_fail_q;
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      err_q <= snd_pkg::ERR_RESET;
      fault_register_b_q <= snd_pkg::FAULT_REGISTER_B_RESET;
    end else begin
      err_q <= (err_clr ? 7'h00 : err_q) | err_set;
      fault_register_b_q <= (err_clr ? 7'h00 : fault_register_b_q) | fault_register_b_set;
    end
  end

  // Tick divider: period is (field + 1) base units
  assign tick_len = 10'((10'(link_cfg[snd_pkg::LINK_TICK_LSB +: snd_pkg::LINK_TICK_W]) + 10'h001)
                    * 10'(snd_pkg::TICK_UNIT_CYC));
  assign tick_stb = tick_cnt_q >= tick_len - 10'h001;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_q <= 10'h000;
    end else begin
      tick_cnt_q <= tick_stb ? 10'h000 : tick_cnt_q + 10'h001;
    end
  end

  // Nibble length in ticks for the current frame part
  always_comb begin
    case (state_q)
      snd_pkg::FR_SYNC: nib_len = snd_pkg::SYNC_TICKS;
      snd_pkg::FR_PAUSE: nib_len = pause_len_q;
      default: nib_len = snd_pkg::NIB_BASE_TICKS + {5'h00, nib_val_q};
    endcase
  end
  assign nib_end = tick_stb && (nib_tick_q == nib_len - 9'h001);
  assign sync_end = nib_end && (state_q == snd_pkg::FR_SYNC);
  assign data_last = long_mode_q ? snd_pkg::DATA_LAST_LONG : snd_pkg::DATA_LAST_SHORT;

  // Status nibble: error summary, self-test busy, serial channel
  assign any_err = |(err_q & ~err_mask[6:0]);
  assign ser_word = {2'h0, fault_register_b_q[4:3], 5'h00, err_q};
  always_comb begin
    status_d = {2'h0, test_busy_q, any_err};
    if (link_cfg[snd_pkg::LINK_SERIAL_BIT]) begin
      status_d[3] = ser_cnt_q == 4'h0;
      status_d[2] = ser_word[4'hF - ser_cnt_q];
    end
  end

  // Frame sequencer
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= snd_pkg::FR_SYNC;
      nib_tick_q <= 9'h000;
      nib_val_q <= 4'h0;
      data_idx_q <= 3'h0;
    end else if (tick_stb) begin
      if (!nib_end) begin
        nib_tick_q <= nib_tick_q + 9'h001;
      end else begin
        nib_tick_q <= 9'h000;
        case (state_q)
          snd_pkg::FR_SYNC: begin
            state_q <= snd_pkg::FR_STATUS;
            nib_val_q <= status_d;
          end
          snd_pkg::FR_STATUS: begin
            state_q <= snd_pkg::FR_DATA;
            data_idx_q <= 3'h0;
            nib_val_q <= nib_of(snap_q, 3'h0);
          end
          snd_pkg::FR_DATA: begin
            if (data_idx_q >= data_last) begin
              state_q <= snd_pkg::FR_CRC;
              nib_val_q <= crc_val;
            end else begin
              data_idx_q <= data_idx_q + 3'h1;
              nib_val_q <= nib_of(snap_q, data_idx_q + 3'h1);
            end
          end
          snd_pkg::FR_CRC: state_q <= link_cfg[snd_pkg::LINK_PAUSE_BIT] ? snd_pkg::FR_PAUSE : snd_pkg::FR_SYNC;
          snd_pkg::FR_PAUSE: state_q <= snd_pkg::FR_SYNC;
          default: state_q <= snd_pkg::FR_SYNC;
        endcase
      end
    end
  end

  // Pause fills the frame out to a constant length
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      frame_tick_q <= 9'h000;
      pause_len_q <= 9'h000;
    end else if (tick_stb) begin
      if (nib_end && (state_q == snd_pkg::FR_PAUSE || (state_q == snd_pkg::FR_CRC &&
          !link_cfg[snd_pkg::LINK_PAUSE_BIT]))) begin
        frame_tick_q <= 9'h000;
      end else begin
        frame_tick_q <= frame_tick_q + 9'h001;
      end
      if (nib_end && state_q == snd_pkg::FR_CRC) begin
        pause_len_q <= snd_pkg::FRAME_TICKS - frame_tick_q - 9'h001;
      end
    end
  end

  // Angle and optional field word are frozen for the whole frame
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      snap_q <= 24'h000000;
      long_mode_q <= 1'b0;
      ser_cnt_q <= 4'h0;
    end else if (sync_end) begin
      long_mode_q <= link_cfg[snd_pkg::LINK_DATA_MODE_BIT];
      snap_q <= {angle_in, link_cfg[snd_pkg::LINK_DATA_MODE_BIT] ? field_level : 12'h000};
      ser_cnt_q <= link_cfg[snd_pkg::LINK_SERIAL_BIT] ? ser_cnt_q + 4'h1 : 4'h0;
    end
  end

  snd_crc4 u_crc (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .start(sync_end),
    .feed(nib_end && (state_q == snd_pkg::FR_STATUS || (state_q == snd_pkg::FR_DATA && data_idx_q < data_last))),
    .nib(sync_end ? status_d : nib_of(snap_q, state_q == snd_pkg::FR_STATUS ? 3'h0 : data_idx_q + 3'h1)),
    .crc(crc_val)
  );

  // Line is low for the first five ticks of every nibble
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      link_out_q <= 1'b1;
    end else begin
      link_out_q <= nib_tick_q >= snd_pkg::NIB_LOW_TICKS;
    end
  end

  // Logic self-test: twin LFSRs must agree for the whole run
  assign lt_start = ctrl_wr && reg_req.wdata[snd_pkg::CTRL_LOGIC_TEST_BIT] && !lt_busy_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lt_busy_q <= 1'b0;
      lt_fail_q <= 1'b0;
      lt_done_q <= 1'b0;
      lt_pass_q <= 1'b0;
      lt_cnt_q <= 18'h00000;
      lfsr_a_q <= snd_pkg::LFSR_SEED;
      lfsr_b_q <= snd_pkg::LFSR_SEED;
    end else begin
      lt_done_q <= 1'b0;
      if (lt_start) begin
        lt_busy_q <= 1'b1;
        lt_fail_q <= 1'b0;
        lt_cnt_q <= 18'h00000;
        lfsr_a_q <= snd_pkg::LFSR_SEED;
        lfsr_b_q <= snd_pkg::LFSR_SEED;
      end else if (lt_busy_q) begin
        lfsr_a_q <= lfsr_step(lfsr_a_q);
        lfsr_b_q <= lfsr_step(lfsr_b_q);
        lt_fail_q <= lt_fail_q || (lfsr_a_q != lfsr_b_q) || logic_fault_s;
        lt_cnt_q <= lt_cnt_q + 18'h00001;
        if (lt_cnt_q == 18'(LOGIC_TEST_CYCLES - 1)) begin
          lt_busy_q <= 1'b0;
          lt_done_q <= 1'b1;
          lt_pass_q <= !lt_fail_q;
        end
      end
    end
  end

  // Ring sweep: one bias step per element, one stored angle per step
  assign rt_start = ((ctrl_wr && reg_req.wdata[snd_pkg::CTRL_RING_TEST_BIT]) || ring_req_link)
                    && !ring_bias_en_q;
  assign ring_wr = ring_bias_en_q && (rt_step_q == 8'(snd_pkg::RING_STEP_CYC - 1));
  assign angle_diff = angle_in - {ring_bias_sel_q, 7'h00};
  assign angle_bad = angle_diff > snd_pkg::RING_TOL && angle_diff < (12'h000 - snd_pkg::RING_TOL);
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ring_bias_en_q <= 1'b0;
      ring_bias_sel_q <= 5'h00;
      rt_step_q <= 8'h00;
    end else if (rt_start) begin
      ring_bias_en_q <= 1'b1;
      ring_bias_sel_q <= 5'h00;
      rt_step_q <= 8'h00;
    end else if (ring_bias_en_q) begin
      rt_step_q <= ring_wr ? 8'h00 : rt_step_q + 8'h01;
      if (ring_wr) begin
        if (ring_bias_sel_q == 5'(snd_pkg::RING_ELEMENTS - 1)) begin
          ring_bias_en_q <= 1'b0;
        end else begin
          ring_bias_sel_q <= ring_bias_sel_q + 5'h01;
        end
      end
    end
  end

  snd_ring_mem u_ring_mem (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .wr_en(ring_wr),
    .wr_addr(ring_bias_sel_q),
    .wr_data(angle_in),
    .rd_addr(ring_rd_sel_q),
    .rd_data_q(ring_rd_data)
  );

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      test_busy_q <= 1'b0;
      ring_rd_sel_q <= 5'h00;
    end else begin
      test_busy_q <= lt_busy_q || ring_bias_en_q;
      if (reg_req.wr && reg_req.addr == snd_pkg::ADDR_RING_SEL) begin
        ring_rd_sel_q <= reg_req.wdata[4:0];
      end
    end
  end

  // Read side; unmapped addresses read zero, except bit 2, which undervolt sets on any read
  always_comb begin
    rd_val = 24'h000000;
    case (reg_req.addr)
      snd_pkg::ADDR_ANGLE: rd_val = {11'h000, angle_in, 1'b0};
      snd_pkg::ADDR_ERR: rd_val = {17'h00000, err_q};
      snd_pkg::ADDR_FAULT_REGISTER_B: rd_val = {17'h00000, fault_register_b_q};
      snd_pkg::ADDR_CTRL: rd_val = {18'h00000, lt_pass_q, ring_bias_en_q, lt_busy_q, 3'h0};
      snd_pkg::ADDR_RING_SEL: rd_val = {19'h00000, ring_rd_sel_q};
      snd_pkg::ADDR_RING_DATA: rd_val = {12'h000, ring_rd_data};
      default: rd_val = rd_slot[3] ? cfg_q[rd_slot[2:0]] : 24'h000000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_q <= 24'h000000;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_req.rd;
      if (reg_req.rd) begin
        reg_rdata_q <= rd_val;
        reg_rdata_q[snd_pkg::UV_OUT_BIT] <= rd_val[snd_pkg::UV_OUT_BIT] | undervolt_s;
      end
    end
  end
endmodule // snd_top

//--- sim/snd_top_monitor.sv
// Assertion checker bound to the nibble link transmitter top
`timescale 1ns/1ps
module snd_top_monitor #(
  parameter int unsigned LOGIC_TEST_CYCLES = 20
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input snd_pkg::snd_reg_req_s reg_req,
  input wire logic [23:0] reg_rdata_q,
  input wire logic reg_rvalid_q,
  input snd_pkg::snd_pins_s pins,
  input wire logic [11:0] angle_in,
  input wire logic [11:0] field_level,
  input wire logic ecc_detected,
  input wire logic ecc_corrected,
  input wire logic ring_req_link,
  input wire logic ring_bias_en_q,
  input wire logic [4:0] ring_bias_sel_q,
  input wire logic test_busy_q,
  input wire logic link_out_q
);
  localparam int RING_RUN = snd_pkg::RING_ELEMENTS * snd_pkg::RING_STEP_CYC;
  logic ring_go;
  logic ctrl_wr;
  logic [1:0] clean_q;
  logic [15:0] tick_q;
  logic [15:0] low_q;
  logic [15:0] run_q;
  assign ctrl_wr = reg_req.wr && reg_req.addr == 8'h08;
  assign ring_go = ring_req_link || (ctrl_wr && reg_req.wdata[4]);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // A tick change lands mid-tick, so timing checks wait for two nibble starts
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tick_q <= 16'h000A;
      clean_q <= 2'h1;
    end else if (reg_req.wr && reg_req.addr == 8'h17) begin
      tick_q <= (16'(reg_req.wdata[7:2]) + 16'h0001) * 16'h000A;
      clean_q <= 2'h0;
    end else if ($fell(link_out_q) && clean_q != 2'h2) begin
      clean_q <= clean_q + 2'h1;
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      low_q <= 16'h0000;
      run_q <= 16'h0000;
    end else begin
      low_q <= link_out_q ? 16'h0000 : low_q + 16'h0001;
      run_q <= ring_bias_en_q ? run_q + 16'h0001 : 16'h0000;
    end
  end
  a_read_answer: assert property (reg_rvalid_q == $past(reg_req.rd))
    else $error("read valid does not follow the read strobe");
  a_angle_read: assert property ((!pins.undervolt) [*5] ##1 (reg_req.rd && reg_req.addr == 8'h00) |=>
    reg_rdata_q == {11'h000, $past(angle_in), 1'b0})
    else $error("angle word differs from the angle input");
  a_uv_bit_two: assert property (pins.undervolt [*5] ##1 reg_req.rd |=> reg_rdata_q[2])
    else $error("low supply does not force bit two of the read word");
  a_low_five_ticks: assert property ($rose(link_out_q) && clean_q == 2'h2 |-> low_q == 16'h0005 * tick_q)
    else $error("nibble low interval is not five ticks");
  a_ring_start: assert property (ring_go && !ring_bias_en_q |=> ring_bias_en_q && ring_bias_sel_q == 5'h00)
    else $error("ring sweep did not start on request");
  a_ring_own_req: assert property ($rose(ring_bias_en_q) |-> $past(ring_go))
    else $error("ring sweep started without a request");
  a_ring_step_order: assert property (ring_bias_en_q && $changed(ring_bias_sel_q) |->
    ring_bias_sel_q == $past(ring_bias_sel_q) + 5'h01)
    else $error("ring element skipped or repeated");
  a_ring_sweep_len: assert property ($fell(ring_bias_en_q) |-> run_q == 16'(RING_RUN))
    else $error("ring sweep length is wrong");
  a_logic_test_start: assert property (ctrl_wr && reg_req.wdata[3] && !test_busy_q && !ring_bias_en_q |->
    ##[1:3] test_busy_q)
    else $error("logic self-test did not start");
  cover property ($fell(ring_bias_en_q));
  cover property (pins.undervolt && reg_rvalid_q);
  cover property ($fell(test_busy_q) && !ring_bias_en_q);
endmodule // snd_top_monitor

bind snd_top snd_top_monitor #(.LOGIC_TEST_CYCLES(LOGIC_TEST_CYCLES)) mon_u (
  .ref_clk(ref_clk), .nrst(nrst), .reg_req(reg_req), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
  .pins(pins), .angle_in(angle_in), .field_level(field_level), .ecc_detected(ecc_detected),
  .ecc_corrected(ecc_corrected), .ring_req_link(ring_req_link), .ring_bias_en_q(ring_bias_en_q),
  .ring_bias_sel_q(ring_bias_sel_q), .test_busy_q(test_busy_q), .link_out_q(link_out_q)
);

//--- sim/snd_rx_model.sv
// Behavioural nibble link receiver standing in for the host controller
`timescale 1ns/1ps
module snd_rx_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic link,
  input wire logic ask,
  output logic ring_req_q,
  output logic [15:0] period_q,
  output logic got_q
);
  logic link_q;
  logic [15:0] cnt_q;
  // Only falling edges carry timing; the rise just ends the low delimiter
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      link_q <= 1'b1;
      cnt_q <= 16'h0000;
      period_q <= 16'h0000;
      got_q <= 1'b0;
    end else begin
      link_q <= link;
      cnt_q <= (link_q && !link) ? 16'h0001 : cnt_q + 16'h0001;
      got_q <= link_q && !link;
      if (link_q && !link) begin
        period_q <= cnt_q;
      end
    end
  end
  // One clock long, as the receive path hands it over
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ring_req_q <= 1'b0;
    end else begin
      ring_req_q <= ask;
    end
  end
endmodule // snd_rx_model

//--- sim/tb_top.sv
// Self-checking bench for the nibble link transmitter and diagnostics
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  snd_pkg::snd_reg_req_s reg_req = '0;
  snd_pkg::snd_pins_s pins = '0;
  logic [11:0] angle_in = 12'h000;
  logic [11:0] field_level = 12'hFFF;
  logic ecc_detected = 1'b0;
  logic ecc_corrected = 1'b0;
  logic ask = 1'b0;
  logic ring_track = 1'b0;
  logic ring_req_link, reg_rvalid_q, ring_bias_en_q, test_busy_q, link_out_q, got_q;
  logic [23:0] reg_rdata_q;
  logic [4:0] ring_bias_sel_q;
  logic [15:0] period_q;
  logic [23:0] rq [$];
  logic [15:0] lq [$];
  logic [6:0] eb [5] = '{7'h01, 7'h02, 7'h10, 7'h20, 7'h40};
  logic [23:0] v;
  logic [4:0] src;
  logic sync_seen = 1'b0;
  int err_total = 0;
  int checked = 0;
  int cycles = 0;
  int tick_cyc = 10;
  int seed = 29033;
  always #25 ref_clk = ~ref_clk;
  snd_top #(.LOGIC_TEST_CYCLES(20)) dut_u (
    .ref_clk(ref_clk), .nrst(nrst), .reg_req(reg_req), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
    .pins(pins), .angle_in(angle_in), .field_level(field_level), .ecc_detected(ecc_detected),
    .ecc_corrected(ecc_corrected), .ring_req_link(ring_req_link), .ring_bias_en_q(ring_bias_en_q),
    .ring_bias_sel_q(ring_bias_sel_q), .test_busy_q(test_busy_q), .link_out_q(link_out_q));
  snd_rx_model host_u (.ref_clk(ref_clk), .nrst(nrst), .link(link_out_q), .ask(ask), .ring_req_q(ring_req_link),
    .period_q(period_q), .got_q(got_q));
  task automatic tally_and_finish;
    err_total += lq.size() + rq.size();
    $display("mismatches=%0d comparisons=%0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [23:0] d);
    @(negedge ref_clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(negedge ref_clk);
    reg_req.wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [7:0] a, input logic [23:0] exp);
    rq.push_back(exp);
    @(negedge ref_clk);
    reg_req <= '{addr: a, wdata: 24'h000000, wr: 1'b0, rd: 1'b1};
    @(negedge ref_clk);
    reg_req.rd <= 1'b0;
  endtask
  task automatic idle_wait;
    repeat (3) @(negedge ref_clk);
    repeat (8000) begin
      @(negedge ref_clk);
      if (test_busy_q === 1'b0) break;
    end
  endtask
  function automatic logic [3:0] sh4(input logic [3:0] c);
    logic [3:0] r;
    r = c;
    repeat (4) r = r[3] ? ({r[2:0], 1'b0} ^ 4'hD) : {r[2:0], 1'b0};
    return r;
  endfunction
  // Waits for a whole sync under the new tick, so the frame after it uses the new setup
  task automatic frame(input logic [5:0] tf, input logic lng, input logic pse);
    logic [3:0] n [8];
    logic [3:0] c;
    logic [23:0] d;
    int k;
    int used;
    d = 24'($random(seed));
    angle_in <= d[23:12];
    field_level <= d[11:0];
    bus_wr(8'h17, {3'h0, pse, 8'h00, lng, 3'h0, tf, 2'h0});
    tick_cyc = (int'(tf) + 1) * 10;
    sync_seen = 1'b0;
    repeat (30000) begin
      @(negedge ref_clk);
      if (sync_seen) break;
    end
    bus_rd(8'h00, {11'h000, d[23:12], 1'b0});
    k = lng ? 6 : 3;
    n[0] = 4'h0;
    for (int i = 0; i < 6; i++) n[i + 1] = d[23 - 4 * i -: 4];
    c = 4'h5;
    for (int i = 0; i <= k; i++) c = sh4(c) ^ n[i];
    n[k + 1] = sh4(c);
    used = 56;
    for (int i = 0; i <= k + 1; i++) begin
      used += 12 + int'(n[i]);
      lq.push_back(16'((12 + int'(n[i])) * tick_cyc));
    end
    if (pse) lq.push_back(16'((300 - used) * tick_cyc));
    lq.push_back(16'(56 * tick_cyc));
    repeat (12000) begin
      @(negedge ref_clk);
      if (lq.size() == 0) break;
    end
  endtask
  always @(negedge ref_clk) begin
    cycles++;
    if (ring_track) angle_in <= {ring_bias_sel_q, 7'h00};
    if (reg_rvalid_q === 1'b1) chk(reg_rdata_q, (rq.size() != 0) ? rq.pop_front() : 24'hxxxxxx);
    if (got_q === 1'b1 && lq.size() != 0) chk(24'(period_q), 24'(lq.pop_front()));
    else if (got_q === 1'b1) sync_seen = (period_q === 16'(56 * tick_cyc));
    if (cycles == 90000) begin
      err_total++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (5) @(negedge ref_clk);
    nrst <= 1'b1;
    bus_rd(8'h04, 24'h000001);
    bus_rd(8'h05, 24'h000000);
    for (int i = 0; i < 8; i++) begin
      v = 24'($random(seed));
      if (i == 3) v[7:2] = 6'h00;
      bus_rd(snd_pkg::CFG_ADDR[i], 24'h000000);
      bus_wr(snd_pkg::CFG_ADDR[i], v);
      bus_rd(snd_pkg::CFG_ADDR[i], v);
      bus_wr(snd_pkg::CFG_ADDR[i], 24'h000000);
    end
    bus_wr(8'h03, 24'hFFFFFF);
    bus_rd(8'h03, 24'h000000);
    bus_wr(8'h08, 24'h000001);
    bus_rd(8'h04, 24'h000000);
    bus_wr(8'h18, 24'h000080);
    for (int i = 0; i < 5; i++) begin
      src = 5'h01 << i;
      {ecc_detected, ecc_corrected, pins.temp_bad, pins.supply_lost} <= {src[4:2], src[0]};
      field_level <= src[1] ? 12'h100 : 12'hFFF;
      repeat (4) @(negedge ref_clk);
      {ecc_detected, ecc_corrected, pins.temp_bad, pins.supply_lost} <= 4'h0;
      field_level <= 12'hFFF;
      repeat (4) @(negedge ref_clk);
      bus_rd(8'h04, {17'h00000, eb[i]});
      bus_wr(8'h08, 24'h000001);
    end
    bus_wr(8'h18, 24'h000000);
    pins.undervolt <= 1'b1;
    repeat (5) @(negedge ref_clk);
    bus_rd(8'h03, 24'h000004);
    pins.undervolt <= 1'b0;
    for (int j = 0; j < 2; j++) begin
      pins.logic_fault <= j[0];
      bus_wr(8'h08, 24'h000008);
      idle_wait();
      pins.logic_fault <= 1'b0;
      bus_rd(8'h08, j ? 24'h000000 : 24'h000020);
      bus_rd(8'h05, j ? 24'h000010 : 24'h000000);
    end
    bus_wr(8'h08, 24'h000001);
    ring_track <= 1'b1;
    // Second request lands mid-sweep and must not restart it
    repeat (2) begin
      ask <= 1'b1;
      @(negedge ref_clk);
      ask <= 1'b0;
      repeat (500) @(negedge ref_clk);
    end
    idle_wait();
    bus_rd(8'h05, 24'h000000);
    bus_wr(8'h0A, 24'h000005);
    bus_rd(8'h0B, 24'h000280);
    ring_track <= 1'b0;
    @(negedge ref_clk);
    angle_in <= 12'h800;
    bus_wr(8'h08, 24'h000010);
    idle_wait();
    bus_rd(8'h05, 24'h000008);
    bus_wr(8'h08, 24'h000001);
    for (int i = 0; i < 4; i++) frame(i == 2 ? 6'h02 : 6'(!i[0]), i[0], i[1]);
    tally_and_finish();
  end
endmodule // tb_top
